/* scic_consts.vh */
`ifndef SCIC_CONSTS_VH
`define SCIC_CONSTS_VH
// Register byte offsets
`define SCIC_OFF_CLKCFG 12'h000
`define SCIC_OFF_GPIOBUS 12'h004
`define SCIC_OFF_RIS 12'h008
`define SCIC_OFF_MIS 12'h00C
`define SCIC_OFF_IEN 12'h010
`define SCIC_OFF_ICLR 12'h014
`define SCIC_OFF_SLEEP 12'h018
`define SCIC_OFF_STATUS 12'h01C
`define SCIC_OFF_FLASH 12'h020
// Clock configuration fields
`define SCIC_CFG_DIV_LSB 0
`define SCIC_CFG_DIV_MSB 5
`define SCIC_CFG_USEPLL 6
`define SCIC_CFG_SRC_LSB 8
`define SCIC_CFG_SRC_MSB 10
`define SCIC_CFG_XTAL_LSB 12
`define SCIC_CFG_XTAL_MSB 16
`define SCIC_CFG_INTDIS 20
`define SCIC_CFG_MAINDIS 21
// Oscillator source codes
`define SCIC_SRC_MAIN 3'h0
`define SCIC_SRC_INT 3'h1
`define SCIC_SRC_INT4 3'h2
`define SCIC_SRC_EXT32 3'h3
`define SCIC_SRC_INT30 3'h4
// Interrupt bit positions
`define SCIC_IRQ_MOSC 0
`define SCIC_IRQ_LOCK 1
`define SCIC_IRQ_BOR 2
// Sleep control bits
`define SCIC_SLP_DEEP 0
`define SCIC_SLP_GATE 1
// Reset values
`define SCIC_RST_CLKCFG 32'h0000_0000
`define SCIC_FLASH_BYTES 32'h0004_0000
`endif

/* scic_ctrl.v */
// What this block does
// - System clock divide one to sixty-four
// - One select: loop output or raw oscillator
// - Five oscillator source choices
// - External 32k only with hibernation enabled
// - Separate internal and main oscillator disables
// - Never disable the oscillator clocking device
// - Loop lock sets a status flag
// - Deep-sleep stops processor; gating picks running peripherals
// - Per-port control selects high-speed bus
// - Cleared control means peripheral bus only
// - Three interrupt sources, clear by subset
// - Per-source enables gate the interrupt line
// - Read-only flash capacity in bytes
// - Raw and masked status both readable
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "scic_consts.vh"

module scic_ctrl #(
  parameter [31:0] FLASH_BYTES = `SCIC_FLASH_BYTES,
  parameter HAS_HIB = 1
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Asynchronous event pins
  input wire main_osc_ready,
  input wire loop_lock_in,
  input wire brownout_in,
  input wire hib_enabled,
  input wire wake_event,
  // Clock tree controls
  output reg [5:0] sys_clock_divider_sel,
  output reg clock_from_loop_output,
  output reg [2:0] osc_source_sel,
  output reg [4:0] crystal_freq_sel,
  output reg internal_osc_disable,
  output reg main_osc_disable,
  output reg sys_clk_en,
  // Sleep and bus routing
  output reg cpu_clock_stop,
  output reg periph_gate_deep,
  output reg [7:0] gpio_on_fast_bus,
  // Interrupt
  output reg sys_irq
);

  // ----------------------------------------
  // Registers and synchronisers
  // ----------------------------------------
  // Software requests; divider, loop and source requests are held until the next divide boundary
  reg [5:0] div_req_reg;
  reg use_loop_req_reg;
  reg [2:0] src_req_reg;
  reg [4:0] xtal_reg;
  reg int_dis_req_reg;
  reg main_dis_req_reg;

  // Routing, interrupt and sleep state
  reg [7:0] gpio_reg;
  reg [2:0] ris_reg;
  reg [2:0] ien_reg;
  reg deep_req_reg;
  reg gate_reg;

  // Divider counter, counts up to the active code
  reg [5:0] div_cnt_reg;

  // Pin synchronisers; ev_d_reg only delays for edge detection
  reg [3:0] ev_s1_reg;
  reg [3:0] ev_s2_reg;
  reg [3:0] ev_d_reg;
  reg wake_s1_reg;
  reg wake_s2_reg;

  // Combinational next values and bus qualifiers
  reg [2:0] ris_next;
  reg [31:0] rdata_next;
  wire wr;
  wire rd;
  wire [2:0] ev_rise;
  wire [2:0] clr_bits;
  wire sw_boundary;
  wire [2:0] wr_src;
  wire src_ok;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Register decode, one-function helper for address match
  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  function known_addr;
    input [11:0] a;
    begin
      known_addr = (a[1:0] == 2'h0) && (a <= `SCIC_OFF_FLASH);
    end
  endfunction

  // Oscillator code helpers, shared by the active and the pending source
  function osc_is_internal;
    input [2:0] code;
    begin
      // Both the plain and the divided-by-four choice run the internal oscillator
      osc_is_internal = (code == `SCIC_SRC_INT) || (code == `SCIC_SRC_INT4);
    end
  endfunction

  function osc_is_main;
    input [2:0] code;
    begin
      osc_is_main = (code == `SCIC_SRC_MAIN);
    end
  endfunction

  // A source code is taken only if it exists and, for 32k, if it can run
  function src_accepts;
    input [2:0] code;
    input hib_on;
    begin
      if (code > `SCIC_SRC_INT30) begin
        src_accepts = 1'b0;
      end else if (code == `SCIC_SRC_EXT32) begin
        src_accepts = (HAS_HIB != 0) && hib_on;
      end else begin
        src_accepts = 1'b1;
      end
    end
  endfunction

  // Access happens in setup-then-access; taken in the first access cycle, answered in the second
  assign wr = psel && penable && pwrite && !pready;
  assign rd = psel && penable && !pwrite && !pready;

  // ----------------------------------------
  // Pin synchronisers and events
  // ----------------------------------------
  // Two flops on every pin input before use
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ev_s1_reg <= 4'h0;
      ev_s2_reg <= 4'h0;
      ev_d_reg <= 4'h0;
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
    end else begin
      ev_s1_reg <= {hib_enabled, brownout_in, loop_lock_in, main_osc_ready};
      ev_s2_reg <= ev_s1_reg;
      ev_d_reg <= ev_s2_reg;
      wake_s1_reg <= wake_event;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  // Rising edges of synchronised levels are the events
  // Edges come from the second flop and its delayed copy, never the first
  assign ev_rise = ev_s2_reg[2:0] & ~ev_d_reg[2:0];
  assign clr_bits = (wr && is_addr(paddr, `SCIC_OFF_ICLR)) ? pwdata[2:0] : 3'h0;

  // Source field of a configuration write and whether it may be taken
  assign wr_src = pwdata[`SCIC_CFG_SRC_MSB:`SCIC_CFG_SRC_LSB];
  assign src_ok = src_accepts(wr_src, ev_s2_reg[3]);

  // Sticky status; a new event beats a clear in the same cycle
  always @* begin
    ris_next = (ris_reg & ~clr_bits) | ev_rise;
  end

  // ----------------------------------------
  // Software-written registers
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_req_reg <= 6'h00;
      use_loop_req_reg <= 1'b0;
      src_req_reg <= `SCIC_SRC_MAIN;
      xtal_reg <= 5'h00;
      int_dis_req_reg <= 1'b0;
      main_dis_req_reg <= 1'b0;
      gpio_reg <= 8'h00;
      ien_reg <= 3'h0;
      ris_reg <= 3'h0;
      deep_req_reg <= 1'b0;
      gate_reg <= 1'b0;
    end else begin
      // Status takes its next value every cycle, set winning over clear
      ris_reg <= ris_next;
      // Wake ends deep-sleep; any enabled interrupt counts as wake too
      if (deep_req_reg && (wake_s2_reg || sys_irq)) begin
        deep_req_reg <= 1'b0;
      end
      if (wr && is_addr(paddr, `SCIC_OFF_CLKCFG)) begin
        div_req_reg <= pwdata[`SCIC_CFG_DIV_MSB:`SCIC_CFG_DIV_LSB];
        use_loop_req_reg <= pwdata[`SCIC_CFG_USEPLL];
        // Crystal code is kept as written; software keeps it legal for the loop
        xtal_reg <= pwdata[`SCIC_CFG_XTAL_MSB:`SCIC_CFG_XTAL_LSB];
        int_dis_req_reg <= pwdata[`SCIC_CFG_INTDIS];
        main_dis_req_reg <= pwdata[`SCIC_CFG_MAINDIS];
        // Unknown codes and unavailable 32k keep the old source; the other
        // fields of the same write are still taken
        if (src_ok) begin
          src_req_reg <= wr_src;
        end
      end
      // Bit n moves port n to the fast bus; a cleared bit leaves it on the peripheral bus
      if (wr && is_addr(paddr, `SCIC_OFF_GPIOBUS)) begin
        gpio_reg <= pwdata[7:0];
      end
      // Enables only mask the line; status keeps collecting while masked
      if (wr && is_addr(paddr, `SCIC_OFF_IEN)) begin
        ien_reg <= pwdata[2:0];
      end
      // A sleep write beats a wake in the same cycle, being assigned last
      if (wr && is_addr(paddr, `SCIC_OFF_SLEEP)) begin
        deep_req_reg <= pwdata[`SCIC_SLP_DEEP];
        gate_reg <= pwdata[`SCIC_SLP_GATE];
      end
    end
  end

  // ----------------------------------------
  // Clock enable divider
  // ----------------------------------------
  // Changes apply only at a divide boundary so no enable pulse is cut short
  // A code written mid-period waits for the end of the running period
  // Code zero makes every cycle a boundary, so the enable then stays high
  assign sw_boundary = (div_cnt_reg == sys_clock_divider_sel);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_reg <= 6'h00;
      sys_clock_divider_sel <= 6'h00;
      clock_from_loop_output <= 1'b0;
      osc_source_sel <= `SCIC_SRC_MAIN;
      crystal_freq_sel <= 5'h00;
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= sw_boundary;
      crystal_freq_sel <= xtal_reg;
      if (sw_boundary) begin
        div_cnt_reg <= 6'h00;
        sys_clock_divider_sel <= div_req_reg;
        osc_source_sel <= src_req_reg;
        // Only move onto the loop after it has locked
        if (!use_loop_req_reg || ev_s2_reg[1]) begin
          clock_from_loop_output <= use_loop_req_reg;
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // Oscillator disables, sleep, routing, irq
  // ----------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      internal_osc_disable <= 1'b0;
      main_osc_disable <= 1'b0;
      cpu_clock_stop <= 1'b0;
      periph_gate_deep <= 1'b0;
      gpio_on_fast_bus <= 8'h00;
      sys_irq <= 1'b0;
    end else begin
      // The active source is never switched off, whatever was asked. The
      // pending source is spared too: it must already run when the divide
      // boundary hands the clock over, else the new clock would start dead.
      internal_osc_disable <= int_dis_req_reg && !osc_is_internal(osc_source_sel)
        && !osc_is_internal(src_req_reg);
      main_osc_disable <= main_dis_req_reg && !osc_is_main(osc_source_sel)
        && !osc_is_main(src_req_reg);
      // Deep-sleep and routing outputs are plain registered copies; gating is registered only while deep-sleep is requested
      cpu_clock_stop <= deep_req_reg;
      periph_gate_deep <= deep_req_reg && gate_reg;
      gpio_on_fast_bus <= gpio_reg;
      // Line follows the next status, so a clear drops it without delay
      sys_irq <= |(ris_next & ien_reg);
    end
  end

  // ----------------------------------------
  // APB read mux and answer
  // ----------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    // Write-only and unmapped words read as zero
    case (paddr)
      `SCIC_OFF_CLKCFG: begin
        rdata_next[`SCIC_CFG_DIV_MSB:`SCIC_CFG_DIV_LSB] = div_req_reg;
        rdata_next[`SCIC_CFG_USEPLL] = use_loop_req_reg;
        rdata_next[`SCIC_CFG_SRC_MSB:`SCIC_CFG_SRC_LSB] = src_req_reg;
        rdata_next[`SCIC_CFG_XTAL_MSB:`SCIC_CFG_XTAL_LSB] = xtal_reg;
        rdata_next[`SCIC_CFG_INTDIS] = int_dis_req_reg;
        rdata_next[`SCIC_CFG_MAINDIS] = main_dis_req_reg;
      end
      `SCIC_OFF_GPIOBUS: rdata_next[7:0] = gpio_reg;
      `SCIC_OFF_RIS: rdata_next[2:0] = ris_reg;
      `SCIC_OFF_MIS: rdata_next[2:0] = ris_reg & ien_reg;
      `SCIC_OFF_IEN: rdata_next[2:0] = ien_reg;
      `SCIC_OFF_SLEEP: rdata_next[1:0] = {gate_reg, deep_req_reg};
      `SCIC_OFF_STATUS: rdata_next[9:0] = {osc_source_sel, sys_clock_divider_sel,
                                           clock_from_loop_output};
      `SCIC_OFF_FLASH: rdata_next = FLASH_BYTES;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      // Unmapped or unaligned words answer with an error; writes there are dropped
      pslverr <= psel && penable && !pready && !known_addr(paddr);
      // Read data is captured once, so it stands unchanged while pready is high
      if (rd) begin
        prdata <= rdata_next;
      end
    end
  end

endmodule
`default_nettype wire

/* scic_ctrl_props.sv */
`timescale 1ns/100ps
`default_nettype none
module scic_ctrl_props (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  // Event and level inputs
  input wire logic hib_enabled,
  input wire logic loop_lock_in,
  input wire logic wake_event,
  // Clock tree, sleep and routing
  input wire logic [5:0] sys_clock_divider_sel,
  input wire logic clock_from_loop_output,
  input wire logic [2:0] osc_source_sel,
  input wire logic internal_osc_disable,
  input wire logic main_osc_disable,
  input wire logic sys_clk_en,
  input wire logic cpu_clock_stop,
  input wire logic periph_gate_deep,
  input wire logic [7:0] gpio_on_fast_bus
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Settled divide-by-four gives one enable every fourth cycle, none between
  property p_div4;
    sys_clk_en && sys_clock_divider_sel == 6'h03 && $past(sys_clock_divider_sel, 4) == 6'h03
      |-> $past(sys_clk_en, 4) && !$past(sys_clk_en, 1) && !$past(sys_clk_en, 2)
      && !$past(sys_clk_en, 3);
  endproperty
  a_div4: assert property (p_div4) else $error("divider enable spacing wrong");
  property p_int_keep;
    (osc_source_sel == 3'h1 || osc_source_sel == 3'h2) && $stable(osc_source_sel)
      |-> !internal_osc_disable;
  endproperty
  a_int_keep: assert property (p_int_keep) else $error("active internal osc disabled");
  property p_main_keep;
    osc_source_sel == 3'h0 && $stable(osc_source_sel) |-> !main_osc_disable;
  endproperty
  a_main_keep: assert property (p_main_keep) else $error("active main osc disabled");
  property p_src_legal;
    osc_source_sel <= 3'h4;
  endproperty
  a_src_legal: assert property (p_src_legal) else $error("illegal source code");
  property p_ext32;
    $changed(osc_source_sel) && osc_source_sel == 3'h3 |-> hib_enabled;
  endproperty
  a_ext32: assert property (p_ext32) else $error("32k source without hibernation");
  // Lock input passes two sync flops, so it must have been high earlier
  property p_loop;
    clock_from_loop_output |-> $past(loop_lock_in, 2);
  endproperty
  a_loop: assert property (p_loop) else $error("loop used without lock");
  property p_gate;
    periph_gate_deep |-> cpu_clock_stop;
  endproperty
  a_gate: assert property (p_gate) else $error("gating outside deep-sleep");
  property p_wake;
    wake_event && cpu_clock_stop |-> ##[1:6] !cpu_clock_stop;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not end deep-sleep");
  property p_gpio;
    $changed(gpio_on_fast_bus) |-> $past(psel && penable && pwrite && paddr == 12'h004);
  endproperty
  a_gpio: assert property (p_gpio) else $error("bus routing changed without write");
  // Divider, source and loop selection move only on a divide boundary
  property p_switch;
    $changed(sys_clock_divider_sel) || $changed(osc_source_sel)
      || $changed(clock_from_loop_output) |-> sys_clk_en;
  endproperty
  a_switch: assert property (p_switch) else $error("clock switched off a boundary");
endmodule

bind scic_ctrl scic_ctrl_props u_props (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .hib_enabled, .loop_lock_in, .wake_event, .sys_clock_divider_sel, .clock_from_loop_output,
  .osc_source_sel, .internal_osc_disable, .main_osc_disable, .sys_clk_en, .cpu_clock_stop,
  .periph_gate_deep, .gpio_on_fast_bus);
`default_nettype wire

/* scic_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "scic_consts.vh"
module scic_ctrl_bench;
  // ----------------
  // Signals
  // ----------------
  logic core_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic main_osc_ready = 1'h0, loop_lock_in = 1'h0, brownout_in = 1'h0;
  logic hib_enabled = 1'h0, wake_event = 1'h0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, clock_from_loop_output, internal_osc_disable, main_osc_disable;
  logic sys_clk_en, cpu_clock_stop, periph_gate_deep, sys_irq;
  logic [5:0] sys_clock_divider_sel;
  logic [2:0] osc_source_sel;
  logic [4:0] crystal_freq_sel;
  logic [7:0] gpio_on_fast_bus;
  int failures = 0, checks_done = 0, n_en = 0;
  scic_ctrl DUT (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_osc_ready, .loop_lock_in, .brownout_in, .hib_enabled,
    .wake_event, .sys_clock_divider_sel, .clock_from_loop_output, .osc_source_sel,
    .crystal_freq_sel, .internal_osc_disable, .main_osc_disable, .sys_clk_en,
    .cpu_clock_stop, .periph_gate_deep, .gpio_on_fast_bus, .sys_irq);
  // ----------------
  // Tasks
  // ----------------
  initial forever #5 core_clk = ~core_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One APB transfer; request held until pready is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(r, exp);
  endtask
  // Both oscillator disables always requested, so the active one must be protected
  function automatic logic [31:0] cfg(input logic [5:0] dv, input logic [2:0] sr, input logic lp);
    cfg = {10'h000, 2'h3, 3'h0, 5'h0A, 1'h0, sr, 1'h0, lp, dv};
  endfunction
  task summarize;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    #200000;
    failures++;
    summarize;
  end
  initial begin
    cyc(2);
    resetn <= 1'h1;
    rd(`SCIC_OFF_CLKCFG, `SCIC_RST_CLKCFG);
    xfer(1'h1, `SCIC_OFF_FLASH, 32'h0);
    rd(`SCIC_OFF_FLASH, `SCIC_FLASH_BYTES);
    rd(12'h024, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'h1, `SCIC_OFF_GPIOBUS, 32'hA5);
    cyc(1);
    chk({24'h0, gpio_on_fast_bus}, 32'hA5);
    rd(`SCIC_OFF_GPIOBUS, 32'hA5);
    xfer(1'h1, `SCIC_OFF_GPIOBUS, 32'h0);
    cyc(1);
    chk({24'h0, gpio_on_fast_bus}, 32'h0);
    hib_enabled <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      xfer(1'h1, `SCIC_OFF_CLKCFG, cfg(6'h03, i[2:0], 1'h0));
      cyc(8);
      chk({29'h0, osc_source_sel}, i);
      if (i < 2) chk({30'h0, internal_osc_disable, main_osc_disable}, i == 0 ? 2 : 1);
    end
    hib_enabled <= 1'h0;
    cyc(4);
    xfer(1'h1, `SCIC_OFF_CLKCFG, cfg(6'h3F, 3'h3, 1'h0));
    cyc(8);
    chk({26'h0, sys_clock_divider_sel, osc_source_sel}, {26'h0, 6'h3F, 3'h4});
    xfer(1'h1, `SCIC_OFF_CLKCFG, cfg(6'h00, 3'h5, 1'h0));
    cyc(70);
    chk({26'h0, sys_clock_divider_sel, osc_source_sel}, {26'h0, 6'h00, 3'h4});
    xfer(1'h1, `SCIC_OFF_CLKCFG, cfg(6'h03, 3'h0, 1'h0));
    cyc(8);
    rd(`SCIC_OFF_STATUS, 32'h6);
    n_en = 0;
    repeat (16) begin
      @(posedge core_clk);
      n_en += sys_clk_en;
    end
    chk(n_en, 4);
    loop_lock_in <= 1'h1;
    cyc(8);
    rd(`SCIC_OFF_RIS, 32'h2);
    xfer(1'h1, `SCIC_OFF_CLKCFG, cfg(6'h03, 3'h0, 1'h1));
    cyc(8);
    chk({31'h0, clock_from_loop_output}, 32'h1);
    chk({27'h0, crystal_freq_sel}, 32'hA);
    brownout_in <= 1'h1;
    main_osc_ready <= 1'h1;
    cyc(8);
    chk({31'h0, sys_irq}, 32'h0);
    rd(`SCIC_OFF_RIS, 32'h7);
    rd(`SCIC_OFF_MIS, 32'h0);
    xfer(1'h1, `SCIC_OFF_IEN, 32'h4);
    cyc(3);
    chk({31'h0, sys_irq}, 32'h1);
    rd(`SCIC_OFF_MIS, 32'h4);
    xfer(1'h1, `SCIC_OFF_ICLR, 32'h5);
    cyc(3);
    chk({31'h0, sys_irq}, 32'h0);
    rd(`SCIC_OFF_RIS, 32'h2);
    rd(`SCIC_OFF_ICLR, 32'h0);
    xfer(1'h1, `SCIC_OFF_SLEEP, 32'h3);
    cyc(2);
    chk({30'h0, cpu_clock_stop, periph_gate_deep}, 32'h3);
    wake_event <= 1'h1;
    cyc(8);
    chk({31'h0, cpu_clock_stop}, 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
